/* File: rtl/mac_acc_defs.svh */
// Constants for the accumulate-and-clear block: register indices, reset
// values and operand widths.
// Assumes inclusion by bare name from the package and the design files.
// Function
// RULE1: Y write multiplies by X, accumulates.
// RULE2: Y address read returns accumulator byte 0.
// RULE3: Clear-A write zeroes accumulator, data ignored.
// RULE4: Clear-A read returns byte 3, no clear.
// RULE5: Clear-B write zeroes accumulator likewise.
// RULE6: Clear-B read returns accumulator byte 2.
// RULE7: X write accumulates; X read returns byte 1.
// RULE8: Signed operands, product sign-extended before add.
// RULE9: Accumulator wraps modulo 2^32, no saturation.
`ifndef MAC_ACC_DEFS_SVH
`define MAC_ACC_DEFS_SVH

// ----------------------------------------------------------------
// Register indices; the byte address is four times the index
// ----------------------------------------------------------------
`define U1_X_IDX 8'hac
`define U1_Y_IDX 8'had
`define U1_CLA_IDX 8'hae
`define U1_CLB_IDX 8'haf
`define U0_X_IDX 8'hec
`define U0_Y_IDX 8'hed
`define U0_CLA_IDX 8'hee
`define U0_CLB_IDX 8'hef

// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define OPND_W 8
`define ACC_W 32
`define ACC_RST 32'h0000_0000
`define OPND_RST 8'h00
`define AXI_AW 10
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

/* File: rtl/mac_acc_pkg.sv */
// Types shared by the accumulate block and its register slave.
// Assumes the constants header is on the include path.
`include "mac_acc_defs.svh"
package mac_acc_pkg;
    // Register function selected by the decoded address
    typedef enum logic [2:0]
    {
        FN_NONE,
        FN_X,
        FN_Y,
        FN_CLA,
        FN_CLB
    } reg_fn_t;

    // One access request as seen by a unit
    typedef struct packed
    {
        logic wr;
        reg_fn_t fn;
        logic [`OPND_W-1:0] data;
    } unit_req_t;
endpackage

/* File: rtl/mac_acc_top.sv */
// AXI4-Lite slave and two accumulate units. Byte address = 4 * index.
// Assumes a single master, one write and one read outstanding at most.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "mac_acc_defs.svh"
module mac_acc_top
    import mac_acc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [`AXI_AW-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`AXI_AW-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic aw_held_r;
    logic w_held_r;
    logic [`AXI_AW-1:0] awaddr_r;
    logic [7:0] wbyte_r;
    logic wlane_r;
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic wr_go;
    logic [7:0] widx;
    logic [7:0] ridx;
    logic widx_ok;
    logic ridx_ok;
    unit_req_t req0;
    unit_req_t req1;
    logic [`ACC_W-1:0] acc0;
    logic [`ACC_W-1:0] acc1;
    logic [7:0] rbyte;
    logic rhit;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    // Function chosen by the index's low two bits, unit by its base
    function automatic reg_fn_t fn_of(input logic [7:0] idx);
        reg_fn_t f;
        f = FN_NONE;
        unique case (idx[1:0])
            2'b00: f = FN_X;
            2'b01: f = FN_Y;
            2'b10: f = FN_CLA;
            2'b11: f = FN_CLB;
        endcase
        return f;
    endfunction

    assign aw_hs = s_axi_awvalid && awready_r;
    assign w_hs = s_axi_wvalid && wready_r;
    assign ar_hs = s_axi_arvalid && arready_r;
    assign wr_go = aw_held_r && w_held_r && !bvalid_r;
    assign widx = awaddr_r[9:2];
    assign ridx = s_axi_araddr[9:2];
    assign widx_ok = (widx >= `U1_X_IDX && widx <= `U1_CLB_IDX)
        || (widx >= `U0_X_IDX && widx <= `U0_CLB_IDX);
    assign ridx_ok = (ridx >= `U1_X_IDX && ridx <= `U1_CLB_IDX)
        || (ridx >= `U0_X_IDX && ridx <= `U0_CLB_IDX);

    // Byte lane 0 must be strobed; other lanes are ignored
    assign req0.wr = wr_go && wlane_r && widx[7:2] == 6'(`U0_X_IDX >> 2);
    assign req0.fn = fn_of(widx);
    assign req0.data = wbyte_r;
    assign req1.wr = wr_go && wlane_r && widx[7:2] == 6'(`U1_X_IDX >> 2);
    assign req1.fn = fn_of(widx);
    assign req1.data = wbyte_r;

    // One unit per block of four indices; unit 0 owns the upper block
    logic [`ACC_W-1:0] acc_u [2];
    for (genvar u = 0; u < 2; u++)
    begin : g_unit
        mac_unit mac_unit_inst
        (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .req((u == 0) ? req0 : req1),
            .acc(acc_u[u])
        );
    end
    assign acc0 = acc_u[0];
    assign acc1 = acc_u[1];

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    // Reads never touch the accumulator: pure byte selection
    logic [`ACC_W-1:0] racc;
    assign racc = (ridx[7:2] == 6'(`U0_X_IDX >> 2)) ? acc0 : acc1;
    assign rhit = ridx_ok;
    assign rbyte = (ridx[1:0] == 2'b01) ? racc[7:0] // RULE2
        : (ridx[1:0] == 2'b00) ? racc[15:8] // RULE7
        : (ridx[1:0] == 2'b11) ? racc[23:16] // RULE6
        : racc[31:24]; // RULE4

    // Write channels: each address and data taken independently
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= '0;
            wbyte_r <= 8'h00;
            wlane_r <= 1'b0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= `RESP_OKAY;
        end
        else
        begin
            awready_r <= !aw_held_r && !aw_hs && !bvalid_r;
            wready_r <= !w_held_r && !w_hs && !bvalid_r;
            if (aw_hs)
            begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (w_hs)
            begin
                w_held_r <= 1'b1;
                wbyte_r <= s_axi_wdata[7:0];
                wlane_r <= s_axi_wstrb[0];
            end
            if (wr_go)
            begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= widx_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (bvalid_r && s_axi_bready)
                bvalid_r <= 1'b0;
        end
    end

    // Read channel: one read in flight, data registered
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= `RESP_OKAY;
        end
        else
        begin
            arready_r <= !rvalid_r && !ar_hs;
            if (ar_hs)
            begin
                rvalid_r <= 1'b1;
                rdata_r <= rhit ? {24'h00_0000, rbyte} : 32'h0000_0000;
                rresp_r <= rhit ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (rvalid_r && s_axi_rready)
                rvalid_r <= 1'b0;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_read_byte0: assert property (@(posedge core_clk) // RULE2
        disable iff (!rst_n)
        ar_hs && ridx == `U0_Y_IDX |=> rdata_r == {24'h0, $past(acc0[7:0])})
        else $error("byte0 read wrong");
    a_read_byte3: assert property (@(posedge core_clk) // RULE4
        disable iff (!rst_n)
        ar_hs && ridx == `U1_CLA_IDX |=>
        rdata_r == {24'h0, $past(acc1[31:24])})
        else $error("byte3 read wrong");
    a_read_byte2: assert property (@(posedge core_clk) // RULE6
        disable iff (!rst_n)
        ar_hs && ridx == `U0_CLB_IDX |=>
        rdata_r == {24'h0, $past(acc0[23:16])})
        else $error("byte2 read wrong");
    // The accumulator is cleared at the very edge the write is applied
    a_clear_b: assert property (@(posedge core_clk) // RULE5
        disable iff (!rst_n)
        req1.wr && req1.fn == FN_CLB |=> acc1 == 32'h0)
        else $error("clear-B did not zero");
    // While the response stands, no new write may be accepted
    a_resp_after: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        wr_go |=> bvalid_r && !s_axi_awready && !s_axi_wready)
        else $error("write response missing or readies high");
endmodule
`default_nettype wire

/* File: rtl/mac_unit.sv */
// One multiply-accumulate unit: X and Y operands, 32-bit accumulator.
// Assumes one request per cycle from the register slave on core_clk.
`timescale 1ns/100ps
`default_nettype none
`include "mac_acc_defs.svh"
module mac_unit
    import mac_acc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire unit_req_t req,
    output logic [`ACC_W-1:0] acc
);
    logic [`OPND_W-1:0] x_r;
    logic [`OPND_W-1:0] y_r;
    logic [`ACC_W-1:0] acc_r;
    logic [`ACC_W-1:0] acc_nxt;
    logic signed [`OPND_W-1:0] mul_a;
    logic signed [`OPND_W-1:0] mul_b;
    logic signed [2*`OPND_W-1:0] prod;
    logic [`ACC_W-1:0] prod_ext;
    logic is_x;
    logic is_y;
    logic is_clr;

    // ----------------------------------------------------------------
    // Operand selection and product
    // ----------------------------------------------------------------
    // Written value pairs with the other, currently held operand
    assign is_x = req.wr && (req.fn == FN_X);
    assign is_y = req.wr && (req.fn == FN_Y);
    assign is_clr = req.wr && (req.fn == FN_CLA || req.fn == FN_CLB);
    assign mul_a = is_x ? req.data : x_r; // RULE7
    assign mul_b = is_y ? req.data : y_r; // RULE1
    assign prod = mul_a * mul_b; // RULE8
    // Sign extension keeps negative products correct
    assign prod_ext = {{(`ACC_W-2*`OPND_W){prod[2*`OPND_W-1]}}, prod};
    // Plain add truncates to 32 bits, so overflow wraps silently
    assign acc_nxt = is_clr ? `ACC_RST
        : (is_x || is_y) ? acc_r + prod_ext : acc_r; // RULE9 RULE3 RULE5
    assign acc = acc_r;

    // Operand and accumulator registers
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            x_r <= `OPND_RST;
            y_r <= `OPND_RST;
            acc_r <= `ACC_RST;
        end
        else
        begin
            if (is_x)
                x_r <= req.data;
            if (is_y)
                y_r <= req.data;
            acc_r <= acc_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // Reference sums come from the operands, not from the multiplier,
    // so a broken product or extension cannot hide behind itself
    a_clear_zeroes: assert property (@(posedge core_clk) // RULE3
        disable iff (!rst_n)
        is_clr |=> acc_r == 32'h0)
        else $error("accumulator not cleared");
    a_y_accum: assert property (@(posedge core_clk) // RULE1
        disable iff (!rst_n)
        is_y |=> $signed(acc_r) == $signed($past(acc_r))
        + $signed($past(req.data)) * $signed($past(x_r)))
        else $error("Y write did not accumulate");
    a_x_accum: assert property (@(posedge core_clk) // RULE7
        disable iff (!rst_n)
        is_x |=> $signed(acc_r) == $signed($past(acc_r))
        + $signed($past(req.data)) * $signed($past(y_r)))
        else $error("X write did not accumulate");
    a_idle_hold: assert property (@(posedge core_clk) // RULE4
        disable iff (!rst_n)
        !req.wr |=> $stable(acc_r))
        else $error("accumulator moved without write");
    a_sign_ext: assert property (@(posedge core_clk) // RULE8
        disable iff (!rst_n)
        $signed(prod_ext) == $signed(mul_a) * $signed(mul_b))
        else $error("product not sign-extended");
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench: AXI4-Lite master plus a byte-level accumulator model.
// Assumes the design package and constants header are on the include path.
`timescale 1ns/100ps
`default_nettype none
`include "mac_acc_defs.svh"
module tb
    import mac_acc_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [9:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [1:0] exp_b[$];
    logic [33:0] exp_r[$];
    logic [31:0] acc_m[2] = '{32'h0, 32'h0};
    logic [7:0] xo_m[2] = '{8'h0, 8'h0};
    logic [7:0] yo_m[2] = '{8'h0, 8'h0};
    logic [31:0] r;
    int seed = 6;
    int cycles = 0;
    int miscompares = 0;
    int check_count = 0;

    mac_acc_top mac_acc_top_inst (.core_clk(core_clk), .rst_n(rst_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));

    // Clock, plus a cycle ceiling so a stuck handshake still ends the run
    always #2 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            miscompares = miscompares + 1;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (miscompares == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Result checking
    // ------------------------------------------------------------
    // An empty queue yields unknowns, so a stray response always fails
    task automatic cmp_b(input logic [1:0] got);
        logic [1:0] want;
        want = (exp_b.size() > 0) ? exp_b.pop_front() : 2'bxx;
        check_count = check_count + 1;
        if (got !== want)
        begin
            miscompares = miscompares + 1;
            $display("BAD %0t bresp %h want %h", $time, got, want);
        end
    endtask

    task automatic cmp_r(input logic [33:0] got);
        logic [33:0] want;
        want = (exp_r.size() > 0) ? exp_r.pop_front() : 'x;
        check_count = check_count + 1;
        if (got !== want)
        begin
            miscompares = miscompares + 1;
            $display("BAD %0t read %h want %h", $time, got, want);
        end
    endtask

    // Watcher sees the same pre-edge values as the slave does
    always @(posedge core_clk)
    begin
        if (s_axi_bvalid === 1'b1 && s_axi_bready)
            cmp_b(s_axi_bresp);
        if (s_axi_rvalid === 1'b1 && s_axi_rready)
            cmp_r({s_axi_rresp, s_axi_rdata});
    end

    // ------------------------------------------------------------
    // Bus master and model
    // ------------------------------------------------------------
    // Each task starts one edge late so no signal is driven twice at once
    task automatic axi_wr(input logic [9:0] a, input logic [31:0] d,
        input logic [3:0] s, input logic [1:0] want);
        logic aw_p;
        logic w_p;
        aw_p = 1'b1;
        w_p = 1'b1;
        exp_b.push_back(want);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (aw_p || w_p)
        begin
            @(posedge core_clk);
            aw_p = aw_p && s_axi_awready !== 1'b1;
            w_p = w_p && s_axi_wready !== 1'b1;
            s_axi_awvalid <= aw_p;
            s_axi_wvalid <= w_p;
        end
        do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [9:0] a, input logic [1:0] want,
        input logic [31:0] d);
        exp_r.push_back({want, d});
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge core_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask

    // Slot k: 0 X operand, 1 Y operand, 2 clear A, 3 clear B
    function automatic logic [9:0] addr_of(input int u, input int k);
        logic [9:0] base;
        base = (u == 1) ? {`U1_X_IDX, 2'b00} : {`U0_X_IDX, 2'b00};
        return base + 10'(k * 4);
    endfunction

    function automatic logic [31:0] rd_exp(input int u, input int k);
        int sh;
        sh = (k == 0) ? 8 : (k == 1) ? 0 : (k == 2) ? 24 : 16;
        return (acc_m[u] >> sh) & 32'hff;
    endfunction

    // Model updates before issue; lane 0 strobe low means no effect
    task automatic wr_reg(input int u, input int k, input logic [31:0] d,
        input logic [3:0] s);
        logic signed [31:0] p;
        if (s[0] && k == 0)
            xo_m[u] = d[7:0];
        if (s[0] && k == 1)
            yo_m[u] = d[7:0];
        p = $signed(xo_m[u]) * $signed(yo_m[u]);
        if (s[0] && k < 2)
            acc_m[u] = acc_m[u] + p;
        if (s[0] && k >= 2)
            acc_m[u] = 32'h0;
        axi_wr(addr_of(u, k), d, s, `RESP_OKAY);
    endtask

    task automatic chk_unit(input int u);
        for (int k = 0; k < 4; k++)
            axi_rd(addr_of(u, k), `RESP_OKAY, rd_exp(u, k));
    endtask

    // Reset values, signed products, both clears, unmapped, then random
    initial
    begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        chk_unit(0);
        chk_unit(1);
        wr_reg(0, 0, 32'hffff_ff85, 4'h1);
        wr_reg(0, 1, 32'h0000_007f, 4'hf);
        wr_reg(0, 1, 32'h0000_0080, 4'h1);
        wr_reg(0, 0, 32'h0000_00ff, 4'h1);
        chk_unit(0);
        chk_unit(1);
        wr_reg(0, 2, 32'h0000_00ff, 4'h1);
        wr_reg(1, 0, 32'h0000_0080, 4'h1);
        wr_reg(1, 1, 32'h0000_0080, 4'h1);
        wr_reg(1, 1, 32'h0000_0080, 4'h1);
        chk_unit(0);
        chk_unit(1);
        wr_reg(1, 3, 32'h0000_005a, 4'h1);
        chk_unit(1);
        axi_wr(10'h000, 32'h1, 4'hf, `RESP_SLVERR);
        axi_rd(10'h2a0, `RESP_SLVERR, 32'h0);
        for (int i = 0; i < 80; i++)
        begin
            r = $random(seed);
            wr_reg(r[0], r[2:1], $random(seed), r[6:3]);
            axi_rd(addr_of(r[7], r[9:8]), `RESP_OKAY, rd_exp(r[7], r[9:8]));
        end
        chk_unit(0);
        chk_unit(1);
        // Mid-run reset between transfers clears accumulators and operands
        rst_n <= 1'b0;
        acc_m = '{32'h0, 32'h0};
        xo_m = '{8'h0, 8'h0};
        yo_m = '{8'h0, 8'h0};
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        chk_unit(0);
        chk_unit(1);
        // Held operands are zero again, so these add nothing at first
        wr_reg(0, 1, 32'h0000_0055, 4'h1);
        wr_reg(1, 0, 32'h0000_0066, 4'h1);
        wr_reg(0, 0, 32'h0000_0002, 4'h1);
        chk_unit(0);
        chk_unit(1);
        repeat (4) @(posedge core_clk);
        wrap_up();
    end
endmodule
`default_nettype wire
